/* logic/prms_top.sv */
// Pad control: reset pad, mode select, debug line and port pads
`timescale 1ns/1ps
`default_nettype none
`include "prms_consts.svh"
module prms_top (
    input wire logic sys_clk_in, // Bus clock
    input wire logic rst_in, // Power-on reset, async, active high
    input wire logic wdog_reset_req_in, // Other internal reset source
    input wire logic dbg_force_reset_in, // Debug-forced reset, pulse
    input wire logic reset_pad_in, // Reset pad level
    output logic reset_pad_out, // Reset pad data
    output logic reset_pad_oe_out, // Reset pad driver enable
    output logic reset_pad_pullup_out, // Reset pad pullup enable
    output logic chip_reset_out, // Internal reset for the device
    output logic debug_line_mode_out, // Active background mode
    input wire logic debug_pin_enable_wr_in, // Write strobe for the enable
    input wire logic debug_pin_enable_val_in, // Value written
    output logic debug_pin_enable_out, // Debug pin enable bit
    input wire logic debug_pad_in, // Shared debug pad level
    output logic debug_pad_out, // Shared debug pad data
    output logic debug_pad_oe_out, // Shared debug pad driver enable
    output logic debug_pad_pullup_out, // Shared debug pad pullup
    input wire logic [3:0] dbg_clk_div_in, // Debug clock divider
    input wire logic dbg_tx_en_in, // Answer the next bit
    input wire logic dbg_tx_bit_in, // Bit value to answer
    output logic dbg_rx_bit_out, // Level sampled in the last bit
    output logic dbg_bit_done_out, // Bit finished, pulse
    input wire logic comparator_sel_in, // Comparator owns the shared pad
    input wire logic comparator_output_in, // Comparator result
    input wire logic port_cfg_wr_in, // Pad configuration write strobe
    input wire prms_pkg::prms_pad_cfg_t port_cfg_in, // New configuration
    input wire logic [`PRMS_PORT_W-1:0] port_pad_in, // Port pad levels
    output prms_pkg::prms_pad_drv_t port_pad_out, // Port pad drive
    output logic [`PRMS_PORT_W-1:0] port_data_out, // Port input data
    input wire logic serial_bus_en_in, // Two-wire bus owns its pads
    input wire logic serial_data_low_in, // Bus pulls data low
    input wire logic serial_clock_low_in, // Bus pulls clock low
    input wire logic osc_enable_in, // Oscillator requested
    input wire logic osc_ext_clock_in, // External clock, not crystal
    input wire logic osc_stop3_keep_in, // Keep running in stop3
    input wire logic stop3_in, // Device is in stop3
    output logic osc_amp_en_out, // Crystal amplifier enable
    output logic osc_run_out // Oscillator running
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    // Pad inputs arrive from outside and pass two flops first
    logic rst_pad_s; // Reset pad, synchronised
    logic dbg_s; // Debug pad, synchronised
    logic [`PRMS_PORT_W-1:0] port_s; // Port pads, synchronised
    prms_sync2 #(.W(`PRMS_PORT_W + 2)) u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .async_in({reset_pad_in, debug_pad_in, port_pad_in}),
        .sync_out({rst_pad_s, dbg_s, port_s})
    );

    // Open-drain bus pads
    function automatic logic is_od(input logic [2:0] idx);
        return (idx == `PRMS_SDA_BIT) || (idx == `PRMS_SCL_BIT);
    endfunction

    // ---- Reset and mode select state
    logic [4:0] hold_reg, hold_next; // Reset stretch counter
    logic chip_reset_reg, chip_reset_next; // Internal reset level
    logic [2:0] blank_reg, blank_next; // Ignore pad after our own drive
    logic ms_reg, ms_next; // This reset samples mode select
    logic debug_line_reg, debug_line_next; // Latched mode
    logic dpe_reg, dpe_next; // Debug pin enable
    logic pad_src; // Reset pad asserted from outside
    logic any_src; // Any reset source active
    logic release_now; // Last cycle of internal reset

    // Reset sources, stretch, and mode latch at release
    always_comb begin
        // Our own low drive would read back as a pad reset, so the pad
        // counts only while undriven and after a short blanking time
        pad_src = ~rst_pad_s & ~chip_reset_reg & (blank_reg == 3'h0);
        any_src = pad_src | wdog_reset_req_in | dbg_force_reset_in;
        hold_next = hold_reg;
        if (any_src) begin
            hold_next = `PRMS_RST_HOLD;
        end else if (hold_reg != 5'h00) begin
            hold_next = hold_reg - 5'h01;
        end
        chip_reset_next = (hold_next != 5'h00);
        release_now = chip_reset_reg & ~chip_reset_next;
        blank_next = blank_reg;
        if (release_now) begin
            blank_next = `PRMS_PAD_BLANK;
        end else if (blank_reg != 3'h0) begin
            blank_next = blank_reg - 3'h1;
        end
        ms_next = ms_reg;
        if (dbg_force_reset_in) begin
            // Debug-forced reset samples mode select
            ms_next = 1'b1;
        end else if (any_src & ~chip_reset_reg) begin
            // Pad or other resets do not
            ms_next = 1'b0;
        end else if (release_now) begin
            ms_next = 1'b0;
        end
        debug_line_next = debug_line_reg;
        if (release_now) begin
            // Undriven pad reads high: normal mode; held low in a mode-select reset: background
            debug_line_next = ms_reg & ~dbg_s;
        end
        dpe_next = dpe_reg;
        if (chip_reset_reg) begin
            // Every reset sets the enable; reset wins over a write
            dpe_next = 1'b1;
        end else if (debug_pin_enable_wr_in) begin
            dpe_next = debug_pin_enable_val_in;
        end
    end

    // Reset state registers; power-on counts as a mode-select reset
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hold_reg <= `PRMS_RST_HOLD;
            chip_reset_reg <= 1'b1;
            blank_reg <= 3'h0;
            ms_reg <= `PRMS_MS_RST;
            debug_line_reg <= 1'b0;
            dpe_reg <= `PRMS_DPE_RST;
        end else begin
            hold_reg <= hold_next;
            chip_reset_reg <= chip_reset_next;
            blank_reg <= blank_next;
            ms_reg <= ms_next;
            debug_line_reg <= debug_line_next;
            dpe_reg <= dpe_next;
        end
    end

    // Reset pad: pulled up, driven low only while reset is on
    assign reset_pad_out = 1'b0;
    assign reset_pad_oe_out = chip_reset_reg;
    assign reset_pad_pullup_out = 1'b1;
    assign chip_reset_out = chip_reset_reg;
    assign debug_line_mode_out = debug_line_reg;
    assign debug_pin_enable_out = dpe_reg;

    // ---- Debug line bit engine
    prms_pkg::prms_dl_state_t dl_reg, dl_next; // Bit state
    logic dbg_prev_reg; // Debug pad one cycle ago
    logic rx_reg, rx_next; // Sampled bit
    logic done_reg; // Bit done pulse
    logic host_fall; // Host starts a bit
    logic tick; // Debug clock enable
    logic [3:0] tick_cnt; // Tick within the bit
    logic bit_done; // Last tick of the bit

    prms_bit_timer u_timer (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .start_in(host_fall),
        .div_in(dbg_clk_div_in),
        .tick_out(tick),
        .cnt_out(tick_cnt),
        .done_out(bit_done)
    );

    // Bit sequencing; a falling edge from the host opens each bit
    always_comb begin
        host_fall = dbg_prev_reg & ~dbg_s & dpe_reg & ~chip_reset_reg
            & (dl_reg == prms_pkg::DL_IDLE);
        dl_next = dl_reg;
        rx_next = rx_reg;
        if (tick && tick_cnt == `PRMS_DBG_SAMPLE_TICK) begin
            rx_next = dbg_s;
        end
        case (dl_reg)
            prms_pkg::DL_IDLE: begin
                if (host_fall) begin
                    // A zero is answered by holding the line low
                    dl_next = (dbg_tx_en_in && !dbg_tx_bit_in) ?
                        prms_pkg::DL_LOW : prms_pkg::DL_BIT;
                end
            end
            prms_pkg::DL_LOW: begin
                if (tick && tick_cnt == `PRMS_DBG_LOW_END_TICK) begin
                    dl_next = prms_pkg::DL_SPEEDUP;
                end
            end
            prms_pkg::DL_SPEEDUP: begin
                // Driven high for one tick only, then released
                if (tick) begin
                    dl_next = prms_pkg::DL_BIT;
                end
            end
            prms_pkg::DL_BIT: begin
                if (bit_done) begin
                    dl_next = prms_pkg::DL_IDLE;
                end
            end
            default: begin
                dl_next = prms_pkg::DL_IDLE;
            end
        endcase
        // Losing the debug role aborts any bit at once
        if (!dpe_reg || chip_reset_reg) begin
            dl_next = prms_pkg::DL_IDLE;
        end
    end

    // Debug engine registers
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dl_reg <= prms_pkg::DL_IDLE;
            dbg_prev_reg <= 1'b1;
            rx_reg <= 1'b1;
            done_reg <= 1'b0;
        end else begin
            dl_reg <= dl_next;
            dbg_prev_reg <= dbg_s;
            rx_reg <= rx_next;
            done_reg <= bit_done;
        end
    end
    assign dbg_rx_bit_out = rx_reg;
    assign dbg_bit_done_out = done_reg;

    prms_pkg::prms_pad_cfg_t port_cfg_reg, port_cfg_next; // Pad setup

    // Shared debug pad: mode select, debug line, or output-only port
    always_comb begin
        if (chip_reset_reg) begin
            // Input only during reset so the host can hold it low
            debug_pad_oe_out = 1'b0;
            debug_pad_out = 1'b0;
            debug_pad_pullup_out = 1'b1;
        end else if (dpe_reg) begin
            // Pseudo open drain: low drive, plus a short high pulse
            debug_pad_oe_out = (dl_reg == prms_pkg::DL_LOW)
                | (dl_reg == prms_pkg::DL_SPEEDUP);
            debug_pad_out = (dl_reg == prms_pkg::DL_SPEEDUP);
            debug_pad_pullup_out = 1'b1;
        end else begin
            // Output-only port bit; no pullup can be selected
            debug_pad_oe_out = 1'b1;
            debug_pad_out = comparator_sel_in ? comparator_output_in
                : port_cfg_reg.dout[`PRMS_DBG_BIT];
            debug_pad_pullup_out = 1'b0;
        end
    end

    // ---- Port pad configuration
    logic [`PRMS_PORT_W-1:0] port_data_next; // Sampled pad data
    logic [`PRMS_PORT_W-1:0] bus_low; // Bus pulls a pad low
    logic [`PRMS_PORT_W-1:0] out_w, oe_w, pull_w; // Per-pad drive

    // Configuration changes on a clock edge and clears on reset
    always_comb begin
        port_cfg_next = port_cfg_reg;
        if (chip_reset_reg) begin
            port_cfg_next = `PRMS_CFG_RST;
        end else if (port_cfg_wr_in) begin
            port_cfg_next = port_cfg_in;
        end
        port_data_next = port_s;
    end

    // Configuration registers
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            port_cfg_reg <= `PRMS_CFG_RST;
            port_data_out <= 8'h00;
        end else begin
            port_cfg_reg <= port_cfg_next;
            port_data_out <= port_data_next;
        end
    end

    assign bus_low = (8'h01 << `PRMS_SDA_BIT) & {8{serial_data_low_in}}
        | (8'h01 << `PRMS_SCL_BIT) & {8{serial_clock_low_in}};

    // Per-pad drive; the shared bit lives on the debug pad instead
    for (genvar gi = 0; gi < `PRMS_PORT_W; gi++) begin : g_pad
        localparam logic OD = is_od(3'(gi));
        localparam logic SKIP = (3'(gi) == `PRMS_DBG_BIT);
        logic bus; // Bus function owns this pad
        assign bus = OD & serial_bus_en_in;
        // Open-drain pads never drive high
        assign out_w[gi] = ~SKIP & ~OD & port_cfg_reg.dout[gi];
        assign oe_w[gi] = SKIP ? 1'b0 : bus ? bus_low[gi]
            : OD ? port_cfg_reg.dir[gi] & ~port_cfg_reg.dout[gi]
            : port_cfg_reg.dir[gi];
        // Pullup only on inputs; bus pads keep it except while low
        assign pull_w[gi] = ~SKIP & port_cfg_reg.pull[gi]
            & (bus ? ~bus_low[gi] : ~port_cfg_reg.dir[gi]);
        a_pull_input_only: assert property (
            oe_w[gi] && !bus |-> !pull_w[gi])
            else $error("pullup left on an output pad");
    end
    // One driver for the whole struct, fields in declaration order
    assign port_pad_out = {out_w, oe_w, pull_w};

    // ---- Oscillator control; stop3 halts it unless told to keep it
    logic amp_next, run_next; // Oscillator next state
    always_comb begin
        run_next = osc_enable_in & (~stop3_in | osc_stop3_keep_in);
        amp_next = run_next & ~osc_ext_clock_in;
    end

    // Oscillator registers
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            osc_run_out <= 1'b0;
            osc_amp_en_out <= 1'b0;
        end else begin
            osc_run_out <= run_next;
            osc_amp_en_out <= amp_next;
        end
    end

    // ---- Checks
    a_reset_pad_drive: assert property (
        chip_reset_reg |-> reset_pad_oe_out && !reset_pad_out)
        else $error("reset pad not driven low during reset");
    a_pad_reset_entry: assert property (
        pad_src |=> chip_reset_out [*8])
        else $error("reset pad low did not reset the device");
    a_mode_sel_input: assert property (
        chip_reset_reg |-> !debug_pad_oe_out && debug_pad_pullup_out)
        else $error("debug pad driven during mode select");
    a_debug_after: assert property (
        $fell(chip_reset_reg) |-> debug_pin_enable_out
            && debug_pad_pullup_out && !debug_pad_oe_out)
        else $error("debug role missing after reset");
    a_pin_enable_set: assert property (
        chip_reset_reg ##1 !chip_reset_reg |-> debug_pin_enable_out)
        else $error("reset did not set debug pin enable");
    a_float_normal: assert property (
        $fell(chip_reset_reg) && $past(dbg_s) |-> !debug_line_mode_out)
        else $error("floating pad did not give normal mode");
    a_force_debug_line: assert property (
        $fell(chip_reset_reg) && $past(ms_reg) && !$past(dbg_s)
            |-> debug_line_mode_out)
        else $error("held-low pad did not force background mode");
    a_speedup_short: assert property (
        dl_reg == prms_pkg::DL_SPEEDUP && tick
            |=> !(debug_pad_oe_out && debug_pad_out))
        else $error("speedup pulse longer than one tick");
    a_port_out_only: assert property (
        !chip_reset_reg && !dpe_reg |-> debug_pad_oe_out
            && !debug_pad_pullup_out)
        else $error("shared pad not output only as port");
    a_open_drain: assert property (
        port_pad_out.out[`PRMS_SDA_BIT] == 1'b0
            && port_pad_out.out[`PRMS_SCL_BIT] == 1'b0)
        else $error("bus pad driven high");
    a_bus_pull_cut: assert property (
        serial_bus_en_in && serial_data_low_in
            |-> !port_pad_out.pull[`PRMS_SDA_BIT] && port_pad_out.oe[`PRMS_SDA_BIT])
        else $error("bus pullup on while output low");
    a_osc_stop3: assert property (
        stop3_in && !osc_stop3_keep_in |=> !osc_run_out && !osc_amp_en_out)
        else $error("oscillator ran in stop3 without keep");
    a_pads_reset: assert property (
        chip_reset_reg ##1 !serial_bus_en_in
            |-> port_pad_out.oe == 8'h00 && port_pad_out.pull == 8'h00)
        else $error("pads not high-Z after reset");
    a_cfg_clear: assert property (
        chip_reset_reg && !$past(rst_in) |=> port_cfg_reg == `PRMS_CFG_RST)
        else $error("pad configuration not cleared by reset");
endmodule
`default_nettype wire

/* inc/prms_consts.svh */
// Constants for the pad reset and mode select logic
`ifndef PRMS_CONSTS_SVH
`define PRMS_CONSTS_SVH
// Port width and positions of the special port bits
`define PRMS_PORT_W 8
`define PRMS_SDA_BIT 3'h2
`define PRMS_SCL_BIT 3'h3
`define PRMS_DBG_BIT 3'h4
// Debug bit timing in debug clock ticks, 16 ticks per bit
`define PRMS_DBG_LAST_TICK 4'hF
`define PRMS_DBG_SAMPLE_TICK 4'hA
`define PRMS_DBG_LOW_END_TICK 4'hC
// Reset stretch and reset pad blanking, in bus cycles
`define PRMS_RST_HOLD 5'h10
`define PRMS_PAD_BLANK 3'h4
// Reset values of control state
`define PRMS_DPE_RST 1'b1
`define PRMS_MS_RST 1'b1
`define PRMS_CFG_RST 24'h000000
`endif

/* inc/prms_pkg.sv */
// Types shared by the pad reset and mode select logic
`default_nettype none
package prms_pkg;
    // Software pad configuration, one bit per port pad
    typedef struct packed {
        logic [7:0] dir;  // 1 = output
        logic [7:0] pull; // Pullup enable
        logic [7:0] dout; // Output data
    } prms_pad_cfg_t;
    // Pad drive toward the pad ring
    typedef struct packed {
        logic [7:0] out;  // Output level
        logic [7:0] oe;   // Driver enable
        logic [7:0] pull; // Pullup connected
    } prms_pad_drv_t;
    // Debug line bit states
    typedef enum logic [1:0] {
        DL_IDLE,
        DL_BIT,
        DL_LOW,
        DL_SPEEDUP
    } prms_dl_state_t;
endpackage
`default_nettype wire

/* logic/prms_sync2.sv */
// Two flip-flop synchroniser for pad inputs
`timescale 1ns/1ps
`default_nettype none
module prms_sync2 #(
    parameter int W = 1 // Number of bits synchronised
) (
    input wire logic sys_clk_in, // Bus clock
    input wire logic rst_in, // Async reset, active high
    input wire logic [W-1:0] async_in, // Raw pad levels
    output logic [W-1:0] sync_out // Levels after two flops
);
    logic [W-1:0] meta_reg; // First stage, read only by the second
    // Both stages reset high, the idle level of pulled-up pads
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_reg <= '1;
            sync_out <= '1;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* logic/prms_bit_timer.sv */
// Debug line bit timer: 16 debug clock ticks per bit
`timescale 1ns/1ps
`default_nettype none
`include "prms_consts.svh"
module prms_bit_timer (
    input wire logic sys_clk_in, // Bus clock
    input wire logic rst_in, // Async reset, active high
    input wire logic start_in, // Start a bit, pulse
    input wire logic [3:0] div_in, // Debug clock = bus clock / (div+1)
    output logic tick_out, // One debug clock tick, pulse
    output logic [3:0] cnt_out, // Tick number within the bit
    output logic done_out // Last tick of the bit, pulse
);
    logic [3:0] div_reg, div_next; // Debug clock divider
    logic [3:0] cnt_next; // Tick counter next value
    logic busy_reg, busy_next; // Bit in progress
    logic [4:0] gap_reg, gap_next; // Bus cycles since the start, for the check only
    // Divider gives a one-cycle enable, so one clock serves all rates
    always_comb begin
        tick_out = busy_reg & (div_reg == div_in);
        done_out = tick_out & (cnt_out == `PRMS_DBG_LAST_TICK);
        div_next = div_reg;
        cnt_next = cnt_out;
        busy_next = busy_reg;
        // Wraps on slow debug clocks, which the check below ignores
        gap_next = busy_reg ? gap_reg + 5'h01 : gap_reg;
        if (start_in) begin
            gap_next = 5'h00;
            // A restart always realigns the bit
            div_next = 4'h0;
            cnt_next = 4'h0;
            busy_next = 1'b1;
        end else if (tick_out) begin
            div_next = 4'h0;
            cnt_next = cnt_out + 4'h1;
            busy_next = ~done_out;
        end else if (busy_reg) begin
            div_next = div_reg + 4'h1;
        end
    end
    // Timer registers
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_reg <= 4'h0;
            cnt_out <= 4'h0;
            busy_reg <= 1'b0;
            gap_reg <= 5'h00;
        end else begin
            div_reg <= div_next;
            cnt_out <= cnt_next;
            busy_reg <= busy_next;
            gap_reg <= gap_next;
        end
    end
    // At full rate a bit lasts exactly sixteen bus cycles
    a_bit_sixteen: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        start_in && div_in == 4'h0 |-> ##16 done_out)
        else $error("bit time is not sixteen ticks");
    a_bit_not_early: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        done_out && div_in == 4'h0 |-> gap_reg == 5'h0F)
        else $error("bit ended before sixteen ticks");
endmodule
`default_nettype wire

/* tb/prms_board_model.sv */
// Board wiring and debug host model for the pad control block
`timescale 1ns/1ps
`default_nettype none
module prms_board_model (
    input wire logic sys_clk_in, // Bus clock
    input wire logic host_low_in, // Host pulls the debug line low
    input wire logic ext_rst_low_in, // Board pulls the reset pad low
    input wire logic rst_oe_in, // Device drives the reset pad low
    input wire logic dbg_out_in, // Device debug pad data
    input wire logic dbg_oe_in, // Device debug pad driver enable
    input wire logic dbg_pull_in, // Device debug pad pullup
    input wire prms_pkg::prms_pad_drv_t port_in, // Port pad drive
    output logic rst_level_out, // Reset wire level
    output logic dbg_level_out, // Debug wire level
    output logic [7:0] port_level_out // Port wire levels
);
    // A floating wire wanders every cycle so no stale level can pass
    logic flip_reg = 1'b0;
    always @(posedge sys_clk_in) flip_reg <= ~flip_reg;
    // Reset wire has a pullup; either side may pull it low
    assign rst_level_out = ~(rst_oe_in | ext_rst_low_in);
    // Host only pulls low; speedup pulses come from the device driver
    always_comb begin
        if (dbg_oe_in) begin
            dbg_level_out = dbg_out_in & ~host_low_in;
        end else if (host_low_in) begin
            dbg_level_out = 1'b0;
        end else begin
            dbg_level_out = dbg_pull_in | flip_reg;
        end
    end
    // Released port wires float unless a pullup is on
    assign port_level_out = (port_in.oe & port_in.out) | (~port_in.oe & (port_in.pull | {8{flip_reg}}));
endmodule
`default_nettype wire

/* tb/prms_top_tb_top.sv */
// Self-checking bench for the pad reset and mode select logic
`timescale 1ns/1ps
`default_nettype none
module prms_top_tb_top;
    logic clk = 1'b0, rst = 1'b1, wdog = 1'b0, frc = 1'b0, dwr = 1'b0, dval = 1'b0, txe = 1'b0;
    logic txb = 1'b0, csel = 1'b0, cout = 1'b0, cwr = 1'b0, bus = 1'b0, sdl = 1'b0, scl = 1'b0;
    logic oen = 1'b0, oext = 1'b0, keep = 1'b0, stp = 1'b0, hlow = 1'b0, xrst = 1'b0, lo;
    logic rpo, rpoe, rpu, crst, debug_line, dpe, dpo, dpoe, dpu, rxb, bdone, amp, run, rlev, dlev;
    logic [7:0] plev, pdat;
    logic [3:0] dv = 4'h0; // Debug clock divider
    logic [31:0] r;
    prms_pkg::prms_pad_cfg_t cfg = '0; // Software pad configuration
    prms_pkg::prms_pad_drv_t drv, e; // Seen and expected pad drive
    integer seed = 59, failures = 0, checks_done = 0, n, cyc = 0;
    prms_top i_dut (.sys_clk_in(clk), .rst_in(rst), .wdog_reset_req_in(wdog),
        .dbg_force_reset_in(frc), .reset_pad_in(rlev), .reset_pad_out(rpo), .reset_pad_oe_out(rpoe),
        .reset_pad_pullup_out(rpu), .chip_reset_out(crst), .debug_line_mode_out(debug_line),
        .debug_pin_enable_wr_in(dwr), .debug_pin_enable_val_in(dval), .debug_pin_enable_out(dpe),
        .debug_pad_in(dlev), .debug_pad_out(dpo), .debug_pad_oe_out(dpoe), .debug_pad_pullup_out(dpu),
        .dbg_clk_div_in(dv), .dbg_tx_en_in(txe), .dbg_tx_bit_in(txb), .dbg_rx_bit_out(rxb),
        .dbg_bit_done_out(bdone), .comparator_sel_in(csel), .comparator_output_in(cout),
        .port_cfg_wr_in(cwr), .port_cfg_in(cfg), .port_pad_in(plev), .port_pad_out(drv),
        .port_data_out(pdat), .serial_bus_en_in(bus), .serial_data_low_in(sdl),
        .serial_clock_low_in(scl), .osc_enable_in(oen), .osc_ext_clock_in(oext),
        .osc_stop3_keep_in(keep), .stop3_in(stp), .osc_amp_en_out(amp), .osc_run_out(run));
    prms_board_model i_board (.sys_clk_in(clk), .host_low_in(hlow), .ext_rst_low_in(xrst),
        .rst_oe_in(rpoe), .dbg_out_in(dpo), .dbg_oe_in(dpoe), .dbg_pull_in(dpu), .port_in(drv),
        .rst_level_out(rlev), .dbg_level_out(dlev), .port_level_out(plev));
    initial forever #5 clk = ~clk;
    // Cut a hang short well past the expected run of about 350 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            summarize();
        end
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Power-on reset held three cycles, then wait out the stretch
    task automatic por;
        @(posedge clk) rst <= 1'b1;
        tick(2);
        check({rpoe, dpe, dpu, dpoe, debug_line, rpo, rpu}, 7'b1110001);
        check(drv, 24'h000000);
        @(posedge clk) rst <= 1'b0;
        n = 0;
        while (crst !== 1'b0 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        check({debug_line, crst}, 2'b00);
        $display("test power on reset done");
    endtask
    initial begin
        por();
        // Debug-forced reset with the host holding the pad low
        @(posedge clk) begin hlow <= 1'b1; frc <= 1'b1; end
        @(posedge clk) frc <= 1'b0;
        n = 0;
        do begin @(posedge clk); #1; n++; end while (crst === 1'b1 && n < 40);
        check(n[23:0], 24'h10);
        check({debug_line, dpe}, 2'b11);
        // Watchdog and reset pad sources give normal mode even with the pad low
        for (int s = 0; s < 2; s++) begin
            @(posedge clk) begin wdog <= (s == 0); xrst <= (s == 1); end
            tick(4);
            check({crst, rlev}, 2'b10);
            @(posedge clk) begin wdog <= 1'b0; xrst <= 1'b0; end
            n = 0;
            while (crst === 1'b1 && n < 60) begin @(posedge clk); #1; n++; end
            check({debug_line, crst}, 2'b00);
        end
        @(posedge clk) hlow <= 1'b0;
        tick(8);
        $display("test mode select done");
        // Answered zero and read-back one, at full and at half debug clock rate
        for (int b = 0; b < 4; b++) begin
            @(posedge clk) begin txe <= 1'b1; txb <= b[0]; hlow <= 1'b1; dv <= 4'(b[1]); end
            tick(4);
            @(posedge clk) hlow <= 1'b0;
            tick(4);
            check({dpoe, dlev, dpu}, b[0] ? 3'b011 : 3'b101);
            n = 9;
            while (bdone !== 1'b1 && n < 40) begin @(posedge clk); #1; n++; end
            check(n[23:0], 24'(19 + 16 * b[1]));
            check(rxb, b[0]);
        end
        $display("test debug bits done");
        // Clearing the debug enable hands the shared pad to the port
        @(posedge clk) begin dwr <= 1'b1; dval <= 1'b0; end
        @(posedge clk) dwr <= 1'b0;
        tick(1);
        check(dpe, 1'b0);
        for (int k = 0; k < 20; k++) begin
            r = $random(seed);
            @(posedge clk) begin cwr <= 1'b1; cfg <= r[23:0]; {bus, sdl, scl} <= r[26:24]; end
            @(posedge clk) begin cwr <= 1'b0; {csel, cout, oen, oext, keep, stp} <= r[31:26]; end
            tick(4);
            e = '0;
            for (int i = 0; i < 8; i++) begin
                if (i != 4) begin
                    e.out[i] = (i == 2 || i == 3) ? 1'b0 : cfg.dout[i];
                    e.oe[i] = cfg.dir[i];
                    e.pull[i] = cfg.pull[i] & ~cfg.dir[i];
                end
                if (i == 2 || i == 3) begin
                    lo = (i == 2) ? sdl : scl;
                    e.oe[i] = bus ? lo : cfg.dir[i] & ~cfg.dout[i];
                    if (bus) e.pull[i] = cfg.pull[i] & ~lo;
                end
            end
            check(drv, e);
            check(pdat & ~e.oe & e.pull, ~e.oe & e.pull);
            check({dpoe, dpu, dpo}, {2'b10, csel ? cout : cfg.dout[4]});
            check({run, amp}, {oen & (~stp | keep), oen & (~stp | keep) & ~oext});
        end
        $display("test port pads done");
        // Bus must let go of its pads before reset checks them high-Z
        @(posedge clk) begin bus <= 1'b0; sdl <= 1'b0; scl <= 1'b0; end
        por();
        summarize();
    end
endmodule
`default_nettype wire
